// ### lwwd_top.sv
`timescale 1ns/1ps
module lwwd_top import lwwd_pkg::*; #(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int RST_HOLD_CYC = RST_HOLD_CYC_DEF,
    parameter int LIN_FILT_CYC = LIN_FILT_CYC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode commands from the serial interface
    input wire logic cmd_normal,
    input wire logic cmd_sleep,
    input wire logic cmd_stop,
    input wire logic mode_command_field_wr,
    input wire logic isr_read,
    // Configuration bits
    input wire logic [3:0] input_wake_enable,
    input wire logic [1:0] high_side_switch,
    input wire logic cyclic_or_watchdog_select,
    input wire logic [1:0] period_select_bits,
    input wire logic [1:0] wd_prescale,
    input wire logic receive_only_bit,
    input wire logic mux_active,
    input wire logic [1:0] mux_channel,
    // Pins and analog conditions
    input wire logic [3:0] wake_input,
    input wire logic cs_n,
    input wire logic rst_pin_n,
    input wire logic lin_rx,
    input wire logic vdd_low,
    input wire logic cfg_ground,
    input wire logic cfg_resistor,
    // Outputs
    output logic irq_n,
    output logic rst_out_n,
    output logic regulator_on,
    output logic [1:0] high_side_drive,
    output logic [3:0] wake_input_status,
    output logic wake_src_lx,
    output logic wake_src_lin,
    output logic wake_src_timer,
    output logic watchdog_off_flag,
    output logic wd_timebase_fault,
    output lwwd_state_t mode_state
);
    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [23:0] scaled_len(input int base, input logic [1:0] sel);
        scaled_len = 24'(base) << sel;
    endfunction

    lwwd_state_t st_ff;
    logic [23:0] ms_div_ff;
    logic [23:0] lp_cnt_ff;
    logic [23:0] wd_cnt_ff;
    logic [23:0] nreq_cnt_ff;
    logic [23:0] hold_cnt_ff;
    logic [23:0] lin_cnt_ff;
    logic [23:0] rpin_cnt_ff;
    logic [3:0] lx_snap_ff;
    logic [3:0] lx_en_ff;
    logic [1:0] hs_en_ff;
    logic [1:0] per_sel_ff;
    logic cyc_mode_ff;
    logic frc_mode_ff;
    logic cs_n_q_ff;
    logic lin_q_ff;
    logic irq_n_ff;
    logic src_lx_ff;
    logic src_lin_ff;
    logic src_tmr_ff;
    logic wd_off_ff;
    logic wd_fault_ff;
    logic rst_out_n_ff;
    logic reg_on_ff;
    logic [1:0] hs_drv_ff;
    logic [3:0] lx_stat_ff;

    // ********************************************************************
    // Decoding
    // ********************************************************************
    wire ms_tick = (ms_div_ff == 24'(MS_CYC - 1));
    wire in_stop = (st_ff == ST_STOP);
    wire in_sleep = (st_ff == ST_SLEEP);
    wire low_pwr = in_stop | in_sleep;
    wire [3:0] mux_mask = mux_active ? (4'h1 << mux_channel) : 4'h0;
    wire [3:0] lx_diff = (wake_input ^ lx_snap_ff) & lx_en_ff;
    wire [23:0] per_len = scaled_len(CYC_BASE_MS, per_sel_ff);
    wire per_last = (lp_cnt_ff == per_len - 24'h00_0001);
    wire per_end = low_pwr & ms_tick & per_last;
    wire nxt_cyc_mode = cyclic_or_watchdog_select & (|high_side_switch);
    wire nxt_frc_mode = cyclic_or_watchdog_select & ~(|high_side_switch);
    wire dir_wake = low_pwr & ~cyc_mode_ff & (|lx_diff);
    wire cyc_wake = cyc_mode_ff & per_end & (|lx_diff);
    wire frc_wake = frc_mode_ff & per_end;
    wire lin_long = (lin_cnt_ff >= 24'(LIN_FILT_CYC));
    wire lin_rise = lin_rx & ~lin_q_ff;
    wire lin_wake = low_pwr & lin_rise & lin_long & ~(in_stop & receive_only_bit);
    wire cs_wake = in_stop & cs_n & ~cs_n_q_ff;
    wire rpin_low = (rpin_cnt_ff == 24'(GLITCH_CYC));
    wire rpin_wake = in_stop & rpin_low;
    wire irq_wake = dir_wake | cyc_wake | frc_wake | lin_wake;
    wire any_wake = irq_wake | cs_wake | rpin_wake;
    wire [23:0] wd_len = scaled_len(cfg_resistor ? WD_EXT_MS : WD_INT_MS, wd_prescale);
    wire [23:0] wd_half = {1'b0, wd_len[23:1]};
    wire wd_bad_clr = mode_command_field_wr & (wd_cnt_ff < wd_half);
    wire wd_ovf = ms_tick & (wd_cnt_ff == wd_len - 24'h00_0001);
    wire wd_fail = (st_ff == ST_NORMAL) & ~wd_off_ff & (wd_bad_clr | wd_ovf);
    wire nreq_to = (st_ff == ST_NREQ) & ms_tick
        & (nreq_cnt_ff == 24'(NREQ_TIMEOUT_MS - 1));
    wire rst_cause = vdd_low | rpin_low;
    wire hold_done = (hold_cnt_ff == 24'(RST_HOLD_CYC));
    wire lp_enter = (st_ff == ST_NORMAL) & (cmd_sleep | cmd_stop);
    wire [23:0] nxt_lin_cnt = lin_rx ? CNT_RST : (lin_long ? lin_cnt_ff : lin_cnt_ff + 24'h1);
    wire [23:0] nxt_rpin_cnt = rst_pin_n ? CNT_RST
        : (rpin_low ? rpin_cnt_ff : rpin_cnt_ff + 24'h1);

    // ********************************************************************
    // Mode sequencer
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= ST_RESET;
        end else begin
            case (st_ff)
                ST_RESET: begin
                    if (hold_done && !rst_cause) begin
                        st_ff <= cfg_ground ? ST_NORMAL : ST_NREQ;
                    end
                end
                ST_NREQ: begin
                    if (rst_cause || nreq_to) begin
                        st_ff <= ST_RESET;
                    end else if (cmd_normal) begin
                        st_ff <= ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (rst_cause || wd_fail) begin
                        st_ff <= ST_RESET;
                    end else if (cmd_sleep) begin
                        st_ff <= ST_SLEEP;
                    end else if (cmd_stop) begin
                        st_ff <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (vdd_low) begin
                        st_ff <= ST_RESET;
                    end else if (rpin_wake) begin
                        st_ff <= wd_off_ff ? ST_NORMAL : ST_NREQ;
                    end else if (any_wake) begin
                        st_ff <= ST_NREQ;
                    end
                end
                ST_SLEEP: begin
                    if (irq_wake) begin
                        st_ff <= ST_RESET;
                    end
                end
                default: begin
                    st_ff <= ST_RESET;
                end
            endcase
        end
    end

    // ********************************************************************
    // Timers and filters
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ms_div_ff <= CNT_RST;
            lin_cnt_ff <= CNT_RST;
            rpin_cnt_ff <= CNT_RST;
            cs_n_q_ff <= 1'b1;
            lin_q_ff <= 1'b1;
        end else begin
            ms_div_ff <= ms_tick ? CNT_RST : ms_div_ff + 24'h1;
            lin_cnt_ff <= nxt_lin_cnt;
            rpin_cnt_ff <= nxt_rpin_cnt;
            cs_n_q_ff <= cs_n;
            lin_q_ff <= lin_rx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !low_pwr || per_end) begin
            lp_cnt_ff <= CNT_RST;
        end else if (ms_tick) begin
            lp_cnt_ff <= lp_cnt_ff + 24'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || st_ff != ST_NORMAL || mode_command_field_wr) begin
            wd_cnt_ff <= CNT_RST;
        end else if (ms_tick) begin
            wd_cnt_ff <= wd_cnt_ff + 24'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || st_ff != ST_NREQ) begin
            nreq_cnt_ff <= CNT_RST;
        end else if (ms_tick) begin
            nreq_cnt_ff <= nreq_cnt_ff + 24'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || st_ff != ST_RESET || rst_cause) begin
            hold_cnt_ff <= CNT_RST;
        end else if (!hold_done) begin
            hold_cnt_ff <= hold_cnt_ff + 24'h1;
        end
    end

    // ********************************************************************
    // Low-power configuration capture
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lx_snap_ff <= LX_RST;
            lx_en_ff <= LX_RST;
            hs_en_ff <= 2'h0;
            per_sel_ff <= 2'h0;
            cyc_mode_ff <= 1'b0;
            frc_mode_ff <= 1'b0;
        end else if (lp_enter) begin
            lx_snap_ff <= wake_input;
            lx_en_ff <= input_wake_enable & ~mux_mask;
            hs_en_ff <= high_side_switch;
            per_sel_ff <= period_select_bits;
            cyc_mode_ff <= nxt_cyc_mode;
            frc_mode_ff <= nxt_frc_mode;
        end else if (cyc_mode_ff && per_end) begin
            lx_snap_ff <= wake_input;
        end
    end

    // ********************************************************************
    // Status, interrupt and pin outputs
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_n_ff <= 1'b1;
            src_lx_ff <= 1'b0;
            src_lin_ff <= 1'b0;
            src_tmr_ff <= 1'b0;
        end else begin
            irq_n_ff <= !((in_stop && irq_wake && !vdd_low && !rpin_wake)
                || (!irq_n_ff && !isr_read));
            src_lx_ff <= (dir_wake || cyc_wake) || (src_lx_ff && !isr_read);
            src_lin_ff <= lin_wake || (src_lin_ff && !isr_read);
            src_tmr_ff <= frc_wake || (src_tmr_ff && !isr_read);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wd_off_ff <= 1'b0;
            wd_fault_ff <= 1'b0;
        end else if (st_ff == ST_RESET) begin
            wd_off_ff <= cfg_ground;
            wd_fault_ff <= ~cfg_ground & ~cfg_resistor;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_out_n_ff <= 1'b0;
            reg_on_ff <= 1'b1;
            hs_drv_ff <= 2'h0;
            lx_stat_ff <= LX_RST;
        end else begin
            rst_out_n_ff <= (st_ff != ST_RESET) && !(in_sleep && irq_wake);
            reg_on_ff <= !in_sleep || irq_wake;
            // Switches driven through last millisecond of cyclic period
            hs_drv_ff <= (cyc_mode_ff && low_pwr && per_last) ? hs_en_ff : 2'h0;
            lx_stat_ff <= wake_input;
        end
    end

    assign irq_n = irq_n_ff;
    assign rst_out_n = rst_out_n_ff;
    assign regulator_on = reg_on_ff;
    assign high_side_drive = hs_drv_ff;
    assign wake_input_status = lx_stat_ff;
    assign wake_src_lx = src_lx_ff;
    assign wake_src_lin = src_lin_ff;
    assign wake_src_timer = src_tmr_ff;
    assign watchdog_off_flag = wd_off_ff;
    assign wd_timebase_fault = wd_fault_ff;
    assign mode_state = st_ff;

    // ********************************************************************
    // Checks
    // ********************************************************************
    sequence s_stop_wake;
        in_stop && irq_wake && !vdd_low && !rpin_wake;
    endsequence

    sequence s_sleep_wake;
        in_sleep && irq_wake;
    endsequence

    chk_lp_hold_mode: assert property (@(posedge clk) disable iff (!rst_n)
        in_sleep && !irq_wake |=> st_ff == ST_SLEEP)
        else $error("Sleep left without wake");

    chk_stop_wake_irq: assert property (@(posedge clk) disable iff (!rst_n)
        s_stop_wake |=> st_ff == ST_NREQ && !irq_n)
        else $error("Stop wake without interrupt");

    chk_sleep_wake_reset: assert property (@(posedge clk) disable iff (!rst_n)
        s_sleep_wake |=> !rst_out_n && regulator_on && st_ff == ST_RESET)
        else $error("Sleep wake did not reset host");

    chk_cs_wake_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        in_stop && cs_wake && !irq_wake && irq_n && !isr_read |=> irq_n && st_ff == ST_NREQ)
        else $error("Chip-select wake misbehaved");

    chk_lin_receive_only_bit: assert property (@(posedge clk) disable iff (!rst_n)
        in_stop && receive_only_bit |-> !lin_wake)
        else $error("LIN wake in Stop with receive-only");

    chk_lin_filter: assert property (@(posedge clk) disable iff (!rst_n)
        lin_wake |-> $past(lin_rx) == 1'b0 && lin_cnt_ff >= 24'(LIN_FILT_CYC))
        else $error("LIN wake without long dominant");

    chk_wd_closed_clr: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff == ST_NORMAL && !wd_off_ff && mode_command_field_wr && wd_cnt_ff < wd_half
        |=> st_ff == ST_RESET ##1 !rst_out_n)
        else $error("Closed-window clear not punished");

    chk_nreq_timeout: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff == ST_NREQ |-> nreq_cnt_ff < 24'(NREQ_TIMEOUT_MS))
        else $error("Normal Request outlived timeout");

    chk_rst_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_out_n) |-> $past(hold_cnt_ff) == 24'(RST_HOLD_CYC))
        else $error("Reset released early");

    chk_irq_ack: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_n && isr_read && !in_stop |=> irq_n)
        else $error("Interrupt not released on read");

    chk_timer_excl: assert property (@(posedge clk) disable iff (!rst_n)
        !(cyc_mode_ff && frc_mode_ff))
        else $error("Cyclic and forced both active");

    chk_watchdog_off_flag_normal: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff == ST_RESET && hold_done && !rst_cause && cfg_ground |=> st_ff == ST_NORMAL
        ##1 watchdog_off_flag)
        else $error("Grounded config pin not honoured");
endmodule

// ### lwwd_pkg.sv
package lwwd_pkg;
    localparam int CLK_MHZ = 100;
    // Timing figures in their own units
    localparam int RST_HOLD_US = 1000;
    localparam int NREQ_TIMEOUT_MS = 150;
    localparam int WD_INT_MS = 150;
    localparam int WD_EXT_MS = 100;
    localparam int CYC_BASE_MS = 50;
    localparam int LIN_FILT_US = 70;
    localparam int GLITCH_US = 1;
    localparam int MS_US = 1000;
    // Cycle counts
    localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
    localparam int MS_CYC_DEF = MS_US * CLK_MHZ;
    localparam int RST_HOLD_CYC_DEF = RST_HOLD_US * CLK_MHZ;
    localparam int LIN_FILT_CYC_DEF = LIN_FILT_US * CLK_MHZ;
    // Reset values
    localparam logic [3:0] LX_RST = 4'h0;
    localparam logic [23:0] CNT_RST = 24'h00_0000;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_NREQ,
        ST_NORMAL,
        ST_STOP,
        ST_SLEEP
    } lwwd_state_t;
endpackage

// ### lwwd_host_model.sv
`timescale 1ns/1ps
// ****************
// Host side model
// ****************
module lwwd_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Acknowledge control
    input wire logic ack_en,
    input wire logic [7:0] ack_delay,
    input wire logic poll,
    // Pins
    input wire logic irq_n,
    output logic isr_read
);
    logic [7:0] wait_ff;
    always_ff @(posedge clk) begin
        if (!rst_n || !ack_en || (irq_n && !poll) || isr_read) begin
            wait_ff <= 8'h00;
            isr_read <= 1'b0;
        end else if (wait_ff == ack_delay) begin
            isr_read <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 8'h01;
        end
    end
endmodule

// ### lwwd_tb_top.sv
`timescale 1ns/1ps
module lwwd_tb_top import lwwd_pkg::*;;
    localparam int MSC = 20;
    localparam int HOLD = 30;
    localparam int FILT = 10;
    // ****************
    // Signals
    // ****************
    logic clk = 0, rst_n = 0, cmd_normal = 0, cmd_sleep = 0, cmd_stop = 0;
    logic mode_command_field_wr = 0, isr_read, ack_en = 0, hs_seen = 0, poll = 0;
    logic [7:0] ack_delay = 8'h00;
    logic [3:0] input_wake_enable = 4'h0, wake_input = 4'h0;
    logic [1:0] high_side_switch = 2'h0, period_select_bits = 2'h0, wd_prescale = 2'h0;
    logic cyclic_or_watchdog_select = 0, receive_only_bit = 0, mux_active = 0;
    logic [1:0] mux_channel = 2'h0;
    logic cs_n = 1, rst_pin_n = 1, lin_rx = 1, vdd_low = 0, cfg_ground = 0, cfg_resistor = 1;
    logic irq_n, rst_out_n, regulator_on, wake_src_lx, wake_src_lin, wake_src_timer;
    logic watchdog_off_flag, wd_timebase_fault;
    logic [1:0] high_side_drive;
    logic [3:0] wake_input_status;
    lwwd_state_t mode_state;
    int err_total = 0, cmp_count = 0, n;
    lwwd_top #(.MS_CYC(MSC), .RST_HOLD_CYC(HOLD), .LIN_FILT_CYC(FILT)) i_lwwd_top (
        .clk, .rst_n, .cmd_normal, .cmd_sleep, .cmd_stop, .mode_command_field_wr, .isr_read,
        .input_wake_enable, .high_side_switch, .cyclic_or_watchdog_select, .period_select_bits,
        .wd_prescale, .receive_only_bit, .mux_active, .mux_channel, .wake_input, .cs_n,
        .rst_pin_n, .lin_rx, .vdd_low, .cfg_ground, .cfg_resistor, .irq_n, .rst_out_n,
        .regulator_on, .high_side_drive, .wake_input_status, .wake_src_lx, .wake_src_lin,
        .wake_src_timer, .watchdog_off_flag, .wd_timebase_fault, .mode_state);
    lwwd_host_model i_lwwd_host_model (.clk, .rst_n, .ack_en, .ack_delay, .poll, .irq_n,
        .isr_read);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (high_side_drive === 2'h1) hs_seen = 1'b1;
    end
    // ****************
    // Tasks
    // ****************
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: cmd_normal <= 1'b1;
            1: cmd_stop <= 1'b1;
            2: cmd_sleep <= 1'b1;
            default: mode_command_field_wr <= 1'b1;
        endcase
        @(posedge clk);
        {cmd_normal, cmd_stop, cmd_sleep, mode_command_field_wr} <= 4'h0;
        #1;
    endtask
    task automatic wait_mode(input lwwd_state_t s, input int lim, input string msg);
        int i;
        i = 0;
        while (mode_state !== s && i < lim) begin
            tick(1);
            i++;
        end
        chk(mode_state === s, msg);
    endtask
    task automatic reset_dut(input lwwd_state_t s);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        wait_mode(s, HOLD + 20, "reset exit");
    endtask
    task automatic enter_lp(input bit slp);
        if (mode_state === ST_NREQ) pulse(0);
        pulse(slp ? 2 : 1);
        chk(mode_state === (slp ? ST_SLEEP : ST_STOP), "low power entry");
    endtask
    task automatic woke(input logic [2:0] src, input logic irq, input string msg);
        wait_mode(ST_NREQ, 5, msg);
        chk({wake_src_lx, wake_src_lin, wake_src_timer} === src && irq_n === irq, msg);
    endtask
    task automatic ack(input logic [7:0] d);
        @(posedge clk);
        ack_delay <= d;
        ack_en <= 1'b1;
        tick(20);
        chk(irq_n === 1'b1 && {wake_src_lx, wake_src_lin, wake_src_timer} === 3'h0, "ack");
        ack_en <= 1'b0;
    endtask
    task automatic cs_edge();
        @(posedge clk);
        cs_n <= 1'b0;
        tick(3);
        @(posedge clk);
        cs_n <= 1'b1;
        tick(3);
    endtask
    task automatic pin_wake(input lwwd_state_t s);
        @(posedge clk);
        rst_pin_n <= 1'b0;
        tick(110);
        @(posedge clk);
        rst_pin_n <= 1'b1;
        wait_mode(s, 300, "pin wake");
        chk(irq_n === 1'b1 && {wake_src_lx, wake_src_lin} === 2'h0, "pin wake quiet");
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        #(60000 * 10);
        err_total++;
        $display("MISMATCH %0t timeout", $time);
        conclude();
    end
    initial begin
        reset_dut(ST_NREQ);
        tick(1);
        chk(rst_out_n === 1'b1 && wd_timebase_fault === 1'b0, "boot");
        tick(145 * MSC);
        chk(mode_state === ST_NREQ, "nreq early");
        wait_mode(ST_RESET, 10 * MSC, "nreq timeout");
        tick(2);
        chk(rst_out_n === 1'b0, "nreq host reset");
        wait_mode(ST_NREQ, HOLD + 20, "nreq again");
        @(posedge clk);
        input_wake_enable <= 4'h3;
        enter_lp(0);
        @(posedge clk);
        wake_input[3] <= 1'b1;
        tick(10);
        chk(mode_state === ST_STOP, "disabled input");
        @(posedge clk);
        wake_input[0] <= 1'b1;
        woke(3'h4, 1'b0, "direct wake");
        chk(wake_input_status === 4'h9, "input status");
        ack(8'h00);
        @(posedge clk);
        input_wake_enable <= 4'h4;
        mux_active <= 1'b1;
        mux_channel <= 2'h2;
        enter_lp(0);
        @(posedge clk);
        mux_active <= 1'b0;
        wake_input[2] <= 1'b1;
        tick(10);
        chk(mode_state === ST_STOP, "mux input");
        cs_edge();
        woke(3'h0, 1'b1, "cs wake");
        @(posedge clk);
        input_wake_enable <= 4'h0;
        receive_only_bit <= 1'b1;
        enter_lp(0);
        @(posedge clk);
        lin_rx <= 1'b0;
        repeat (FILT + 5) @(posedge clk);
        lin_rx <= 1'b1;
        tick(3);
        chk(mode_state === ST_STOP, "receive only");
        @(posedge clk);
        receive_only_bit <= 1'b0;
        lin_rx <= 1'b0;
        repeat (FILT - 4) @(posedge clk);
        lin_rx <= 1'b1;
        tick(3);
        chk(mode_state === ST_STOP, "short dominant");
        @(posedge clk);
        lin_rx <= 1'b0;
        tick(3 * FILT);
        chk(mode_state === ST_STOP, "stuck dominant");
        @(posedge clk);
        lin_rx <= 1'b1;
        woke(3'h2, 1'b0, "lin wake");
        ack(8'h05);
        enter_lp(0);
        pin_wake(ST_NREQ);
        @(posedge clk);
        input_wake_enable <= 4'h1;
        enter_lp(1);
        cs_edge();
        chk(regulator_on === 1'b0, "sleep supply");
        chk(mode_state === ST_SLEEP, "cs in sleep");
        @(posedge clk);
        wake_input[0] <= 1'b0;
        tick(2);
        chk(mode_state === ST_RESET && !rst_out_n && regulator_on, "sleep wake");
        wait_mode(ST_NREQ, HOLD + 20, "sleep restart");
        chk(wake_src_lx === 1'b1, "sleep source");
        poll <= 1'b1;
        ack(8'h00);
        poll <= 1'b0;
        @(posedge clk);
        input_wake_enable <= 4'h0;
        cyclic_or_watchdog_select <= 1'b1;
        period_select_bits <= 2'h1;
        enter_lp(0);
        hs_seen = 1'b0;
        tick(95 * MSC);
        chk(mode_state === ST_STOP, "forced early");
        wait_mode(ST_NREQ, 10 * MSC, "forced wake");
        chk(wake_src_timer === 1'b1 && hs_seen === 1'b0, "forced source");
        ack(8'h00);
        @(posedge clk);
        input_wake_enable <= 4'h2;
        high_side_switch <= 2'h1;
        period_select_bits <= 2'h0;
        enter_lp(0);
        hs_seen = 1'b0;
        @(posedge clk);
        wake_input[1] <= 1'b1;
        tick(5 * MSC);
        chk(mode_state === ST_STOP, "cyclic waits");
        wait_mode(ST_NREQ, 50 * MSC, "cyclic wake");
        chk(wake_src_lx && !wake_src_timer && hs_seen === 1'b1, "cyclic source");
        ack(8'h00);
        @(posedge clk);
        cyclic_or_watchdog_select <= 1'b0;
        high_side_switch <= 2'h0;
        pulse(0);
        pulse(3);
        chk(mode_state === ST_RESET, "closed clear");
        tick(1);
        chk(rst_out_n === 1'b0, "closed clear reset");
        n = 0;
        while (rst_out_n !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(n >= HOLD, "reset hold");
        wait_mode(ST_NREQ, 5, "back to nreq");
        pulse(0);
        tick(60 * MSC);
        pulse(3);
        chk(mode_state === ST_NORMAL, "open clear");
        tick(60 * MSC);
        chk(mode_state === ST_NORMAL, "clear restarts");
        wait_mode(ST_RESET, 50 * MSC, "overflow");
        wait_mode(ST_NREQ, HOLD + 20, "after overflow");
        @(posedge clk);
        wd_prescale <= 2'h1;
        pulse(0);
        tick(125 * MSC);
        pulse(3);
        chk(mode_state === ST_NORMAL, "prescaled window");
        @(posedge clk);
        wd_prescale <= 2'h0;
        cfg_ground <= 1'b1;
        reset_dut(ST_NORMAL);
        chk(watchdog_off_flag === 1'b1, "watchdog off");
        @(posedge clk);
        cfg_ground <= 1'b0;
        tick(110 * MSC);
        chk(mode_state === ST_NORMAL && watchdog_off_flag, "no watchdog");
        @(posedge clk);
        cfg_ground <= 1'b1;
        enter_lp(0);
        pin_wake(ST_NORMAL);
        @(posedge clk);
        cfg_ground <= 1'b0;
        cfg_resistor <= 1'b0;
        reset_dut(ST_NREQ);
        chk(wd_timebase_fault && !watchdog_off_flag, "open pin");
        pulse(0);
        tick(125 * MSC);
        chk(mode_state === ST_NORMAL, "internal timebase");
        conclude();
    end
endmodule
